// >>> include/liucrt_defines.svh
// Offsets, field positions, reset values and zero-count thresholds of the
// clock-rate, receive and test control bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LIUCRT_DEFINES_SVH
`define LIUCRT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register addresses on the host register port
// ----------------------------------------------------------------------------
`define LIUCRT_ADDR_W 5
`define LIUCRT_ADDR_CTRL 5'h11
`define LIUCRT_ADDR_GAUGE 5'h12

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LIUCRT_CTRL_RATE_BIT 3
`define LIUCRT_CTRL_MUTE_BIT 2
`define LIUCRT_CTRL_EXLONG_BIT 1
`define LIUCRT_CTRL_TEST_BIT 0
`define LIUCRT_GAUGE_HI_BIT 7
`define LIUCRT_GAUGE_LO_BIT 6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LIUCRT_CTRL_RESET 8'h00
`define LIUCRT_GAUGE_RESET 8'h00

// ----------------------------------------------------------------------------
// Consecutive-zero thresholds for loss of signal, in received bits
// ----------------------------------------------------------------------------
`define LIUCRT_ZERO_CNT_W 13
`define LIUCRT_LOS_EXTENDED 13'h1000
`define LIUCRT_LOS_T1_NOMINAL 13'h00AF
`define LIUCRT_LOS_T1_TOLERANCE 13'h004B
`define LIUCRT_LOS_E1 13'h0020

`endif

// >>> include/liucrt_pkg.sv
// Types shared by the clock-rate, receive and test control bank.
// Assumes the defines header is on the include path.
`include "liucrt_defines.svh"

package liucrt_pkg;

	// Assumed cable wire gauge, upper selector bit first.
	typedef enum logic [1:0] {
		LIUCRT_GAUGE_22_AND_24 = 2'h0,
		LIUCRT_GAUGE_22 = 2'h1,
		LIUCRT_GAUGE_24 = 2'h2,
		LIUCRT_GAUGE_RESERVED = 2'h3
	} liucrt_gauge_t;

	// Line rate that the master clock synthesizer is set to.
	typedef enum logic {
		LIUCRT_RATE_E1 = 1'h0,
		LIUCRT_RATE_T1J1 = 1'h1
	} liucrt_rate_t;

	typedef logic [`LIUCRT_ZERO_CNT_W-1:0] liucrt_zero_cnt_t;

endpackage

// >>> rtl/liucrt_los_detect.sv
// Consecutive-zero counter that declares receive loss of signal.
// Assumes one receive bit strobe per recovered bit, on the master clock.
`timescale 1ns/1ps
`default_nettype none
`include "liucrt_defines.svh"

module liucrt_los_detect
	import liucrt_pkg::*;
#(
	parameter int CNT_W = `LIUCRT_ZERO_CNT_W
) (
	input wire logic clk, // Master clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic bit_strobe, // One pulse per received bit.
	input wire logic bit_value, // Received bit, one means a pulse was seen.
	input wire logic [CNT_W-1:0] threshold, // Zeros needed before loss is declared.
	output logic lost // Loss of signal, from a register.
);

	initial begin
		if (CNT_W < `LIUCRT_ZERO_CNT_W) begin
			$error("liucrt_los_detect: CNT_W too small for the extended threshold");
		end
	end

	logic [CNT_W-1:0] zero_cnt_ff;
	logic [CNT_W-1:0] nxt_zero_cnt;
	logic lost_ff;
	logic nxt_lost;

	// ------------------------------------------------------------------------
	// Zero run counter, saturating at the threshold
	// ------------------------------------------------------------------------
	always_comb begin
		nxt_zero_cnt = zero_cnt_ff;
		nxt_lost = lost_ff;
		if (bit_strobe) begin
			if (bit_value) begin
				nxt_zero_cnt = '0;
				nxt_lost = 1'b0;
			end else if (zero_cnt_ff < threshold) begin
				nxt_zero_cnt = zero_cnt_ff + 1'b1;
				nxt_lost = ((zero_cnt_ff + 1'b1) >= threshold);
			end else begin
				nxt_lost = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zero_cnt_ff <= '0;
		end else begin
			zero_cnt_ff <= nxt_zero_cnt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lost_ff <= 1'b0;
		end else begin
			lost_ff <= nxt_lost;
		end
	end

	assign lost = lost_ff;

endmodule

`default_nettype wire

// >>> rtl/liucrt_top.sv
// Clock-rate, receive mute, extended loss and in-circuit-test control bank
// of a single-channel line interface unit, with its cable gauge register.
// Assumes the host register port, the recovered receive data and the
// recovered clock level all come from logic on the master clock; the
// in-circuit-test pin comes from outside and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "liucrt_defines.svh"

module liucrt_top
	import liucrt_pkg::*;
#(
	parameter int CNT_W = `LIUCRT_ZERO_CNT_W
) (
	input wire logic clk, // Master clock, 200 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic [`LIUCRT_ADDR_W-1:0] reg_addr, // Register address.
	input wire logic reg_wr, // Write strobe, one cycle.
	input wire logic [7:0] reg_wdata, // Write data.
	input wire logic reg_rd, // Read strobe, one cycle.
	output logic [7:0] reg_rdata, // Read data, registered.
	output logic reg_rdata_oe, // Drive enable of the read data.
	input wire logic ict_pin_n, // Hardware in-circuit-test pin, active low.
	input wire logic rx_bit_strobe, // One pulse per recovered bit.
	input wire logic rx_pos_in, // Recovered positive or single-rail data.
	input wire logic rx_neg_in, // Recovered negative data or violation flag.
	input wire logic rx_clk_in, // Recovered receive clock level.
	output logic rx_positive_data_out, // Receive positive data, registered.
	output logic rx_positive_data_out_oe, // Drive enable.
	output logic rx_negative_violation_out, // Receive negative data, registered.
	output logic rx_negative_violation_out_oe, // Drive enable.
	output logic rx_clk_out, // Recovered receive clock, registered.
	output logic rx_clk_out_oe, // Drive enable.
	output logic receive_signal_lost, // Loss of signal, registered.
	output logic receive_signal_lost_oe, // Drive enable.
	output liucrt_rate_t synth_rate_select, // Synthesizer rate, registered.
	output liucrt_gauge_t wire_size_sel // Assumed cable gauge, registered.
);

	initial begin
		if (CNT_W < `LIUCRT_ZERO_CNT_W) begin
			$error("liucrt_top: CNT_W cannot hold the extended threshold");
		end
	end

	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	logic [7:0] ctrl_ff;
	logic [7:0] gauge_ff;
	logic [7:0] rdata_ff;
	logic wr_ctrl;
	logic wr_gauge;

	always_comb begin
		wr_ctrl = 1'b0;
		wr_gauge = 1'b0;
		if (reg_wr && (reg_addr == `LIUCRT_ADDR_CTRL)) begin
			wr_ctrl = 1'b1;
		end else if (reg_wr && (reg_addr == `LIUCRT_ADDR_GAUGE)) begin
			wr_gauge = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= `LIUCRT_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gauge_ff <= `LIUCRT_GAUGE_RESET;
		end else if (wr_gauge) begin
			gauge_ff <= reg_wdata;
		end
	end

	// Unmapped addresses read as zero; writes to them are ignored.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `LIUCRT_ADDR_CTRL) begin
				rdata_ff <= ctrl_ff;
			end else if (reg_addr == `LIUCRT_ADDR_GAUGE) begin
				rdata_ff <= gauge_ff;
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------------------
	logic mute_bit;
	logic exlong_bit;
	logic test_bit;
	liucrt_rate_t rate_sel;
	liucrt_gauge_t gauge_sel;

	assign rate_sel = liucrt_rate_t'(ctrl_ff[`LIUCRT_CTRL_RATE_BIT]);
	assign mute_bit = ctrl_ff[`LIUCRT_CTRL_MUTE_BIT];
	assign exlong_bit = ctrl_ff[`LIUCRT_CTRL_EXLONG_BIT];
	assign test_bit = ctrl_ff[`LIUCRT_CTRL_TEST_BIT];
	// The upper selector bit is D7, the lower D6.
	assign gauge_sel = liucrt_gauge_t'({gauge_ff[`LIUCRT_GAUGE_HI_BIT],
		gauge_ff[`LIUCRT_GAUGE_LO_BIT]});

	// ------------------------------------------------------------------------
	// Test pin synchroniser
	// ------------------------------------------------------------------------
	logic ict_meta_ff;
	logic ict_sync_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ict_meta_ff <= 1'b1;
			ict_sync_ff <= 1'b1;
		end else begin
			ict_meta_ff <= ict_pin_n;
			ict_sync_ff <= ict_meta_ff;
		end
	end

	// Either source alone places the pins in high impedance.
	logic tristate_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tristate_ff <= 1'b0;
		end else begin
			tristate_ff <= test_bit | ~ict_sync_ff;
		end
	end

	// ------------------------------------------------------------------------
	// Loss-of-signal threshold and detector
	// ------------------------------------------------------------------------
	logic [CNT_W-1:0] los_threshold_ff;
	logic los_raw;

	// T1 uses the nominal figure of its 175 +/- 75 window.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			los_threshold_ff <= CNT_W'(`LIUCRT_LOS_E1);
		end else if (exlong_bit) begin
			los_threshold_ff <= CNT_W'(`LIUCRT_LOS_EXTENDED);
		end else if (rate_sel == LIUCRT_RATE_T1J1) begin
			los_threshold_ff <= CNT_W'(`LIUCRT_LOS_T1_NOMINAL);
		end else begin
			los_threshold_ff <= CNT_W'(`LIUCRT_LOS_E1);
		end
	end

	liucrt_los_detect #(
		.CNT_W(CNT_W)
	) u_los_detect (
		.clk(clk),
		.rst(rst),
		.bit_strobe(rx_bit_strobe),
		.bit_value(rx_pos_in | rx_neg_in),
		.threshold(los_threshold_ff),
		.lost(los_raw)
	);

	// ------------------------------------------------------------------------
	// Receive outputs
	// ------------------------------------------------------------------------
	logic rx_pos_ff;
	logic rx_neg_ff;
	logic rx_clk_ff;
	logic los_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_pos_ff <= 1'b0;
			rx_neg_ff <= 1'b0;
		end else if (mute_bit) begin
			rx_pos_ff <= 1'b0;
			rx_neg_ff <= 1'b0;
		end else begin
			rx_pos_ff <= rx_pos_in;
			rx_neg_ff <= rx_neg_in;
		end
	end

	// The clock path ignores the mute bit on purpose.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_clk_ff <= 1'b0;
		end else begin
			rx_clk_ff <= rx_clk_in;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			los_ff <= 1'b0;
		end else begin
			los_ff <= los_raw;
		end
	end

	// ------------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------------
	logic pin_oe;

	assign pin_oe = ~tristate_ff;

	assign rx_positive_data_out = rx_pos_ff;
	assign rx_negative_violation_out = rx_neg_ff;
	assign rx_clk_out = rx_clk_ff;
	assign receive_signal_lost = los_ff;
	assign rx_positive_data_out_oe = pin_oe;
	assign rx_negative_violation_out_oe = pin_oe;
	assign rx_clk_out_oe = pin_oe;
	assign receive_signal_lost_oe = pin_oe;
	assign reg_rdata = rdata_ff;
	assign reg_rdata_oe = pin_oe;
	assign synth_rate_select = rate_sel;
	assign wire_size_sel = gauge_sel;

endmodule

`default_nettype wire

// >>> sim/liucrt_assertions.sv
// Concurrent checks on the ports of the control bank top module.
// Assumes binding onto liucrt_top, one clock, reset asynchronous high.
`timescale 1ns/1ps
`default_nettype none
`include "liucrt_defines.svh"
module liucrt_checker
	import liucrt_pkg::*;
#(
	parameter int CNT_W = `LIUCRT_ZERO_CNT_W
) (
	input wire logic clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic [`LIUCRT_ADDR_W-1:0] reg_addr, // Address.
	input wire logic reg_wr, // Write.
	input wire logic [7:0] reg_wdata, // Write data.
	input wire logic reg_rd, // Read.
	input wire logic [7:0] reg_rdata, // Read data.
	input wire logic reg_rdata_oe, // Enable.
	input wire logic ict_pin_n, // Test pin.
	input wire logic rx_bit_strobe, // Bit strobe.
	input wire logic rx_pos_in, // Data in.
	input wire logic rx_neg_in, // Data in.
	input wire logic rx_clk_in, // Clock in.
	input wire logic rx_positive_data_out, // Data out.
	input wire logic rx_positive_data_out_oe, // Enable.
	input wire logic rx_negative_violation_out, // Data out.
	input wire logic rx_negative_violation_out_oe, // Enable.
	input wire logic rx_clk_out, // Clock out.
	input wire logic rx_clk_out_oe, // Enable.
	input wire logic receive_signal_lost, // Loss.
	input wire logic receive_signal_lost_oe, // Enable.
	input var liucrt_rate_t synth_rate_select, // Rate.
	input var liucrt_gauge_t wire_size_sel // Gauge.
);
	logic [CNT_W-1:0] zrun_ff;
	logic [4:0] oe_v;
	logic ctrl_wr;
	logic gauge_wr;
	assign oe_v = {reg_rdata_oe, rx_positive_data_out_oe, rx_negative_violation_out_oe,
		rx_clk_out_oe, receive_signal_lost_oe};
	assign ctrl_wr = reg_wr && reg_addr == `LIUCRT_ADDR_CTRL;
	assign gauge_wr = reg_wr && reg_addr == `LIUCRT_ADDR_GAUGE;
	// Counts consecutive zero bits seen at the receive input.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zrun_ff <= '0;
		end else if (rx_bit_strobe) begin
			zrun_ff <= (rx_pos_in || rx_neg_in) ? '0 : zrun_ff + 1'b1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	rate_follow_a: assert property (ctrl_wr |=> synth_rate_select == $past(reg_wdata[3]))
		else $error("Rate select does not follow the written bit.");
	mute_out_a: assert property (ctrl_wr && reg_wdata[2] |-> ##2 !rx_positive_data_out &&
		!rx_negative_violation_out) else $error("Receive data not silenced.");
	clk_pass_a: assert property (!$past(rst) |-> rx_clk_out == $past(rx_clk_in))
		else $error("Receive clock output does not follow its input.");
	test_bit_a: assert property (ctrl_wr && reg_wdata[0] |-> ##2 oe_v == 5'h00)
		else $error("Outputs still driven in test mode.");
	oe_equal_a: assert property (oe_v == 5'h00 || oe_v == 5'h1F)
		else $error("Output enables disagree.");
	test_pin_a: assert property (!ict_pin_n [*3] |=> oe_v == 5'h00)
		else $error("Test pin does not release the outputs.");
	gauge_follow_a: assert property (gauge_wr |=> wire_size_sel == $past(reg_wdata[7:6]))
		else $error("Gauge selector does not follow the written bits.");
	gauge_read_a: assert property (gauge_wr ##2 (reg_rd && !reg_wr &&
		reg_addr == `LIUCRT_ADDR_GAUGE) |=> reg_rdata == $past(reg_wdata, 3))
		else $error("Gauge register reads back wrong.");
	los_min_a: assert property ($rose(receive_signal_lost) |-> $past(zrun_ff) >= 32)
		else $error("Loss declared after too few zeros.");
	los_clear_a: assert property (rx_bit_strobe && (rx_pos_in || rx_neg_in) |->
		##2 !receive_signal_lost) else $error("Loss not cleared by a one.");
	cover property (ctrl_wr && reg_wdata[2]);
	cover property ($rose(receive_signal_lost));
	cover property (oe_v == 5'h00);
endmodule
bind liucrt_top liucrt_checker #(.CNT_W(CNT_W)) chk_i (.*);
`default_nettype wire

// >>> sim/liucrt_host_model.sv
// Host processor model on the parallel register port.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "liucrt_defines.svh"
module liucrt_host_model
	import liucrt_pkg::*;
(
	input wire logic clk, // Clock.
	output logic [`LIUCRT_ADDR_W-1:0] reg_addr, // Address.
	output logic reg_wr, // Write strobe.
	output logic [7:0] reg_wdata, // Write data.
	output logic reg_rd, // Read strobe.
	input wire logic [7:0] reg_rdata // Read data.
);
	initial begin
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// Released address and write-data lines show the inverse so a stale value is never mistaken for a live one.
	task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(posedge clk);
		#1;
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_liucrt_top.sv
// Self-checking bench of the control bank through its register port.
// Assumes the host model and the bound checker are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
`include "liucrt_defines.svh"
module tb_liucrt_top;
	import liucrt_pkg::*;
	localparam logic [7:0] LOS_CFG [3] = '{8'h00, 8'h08, 8'h02};
	localparam int LOS_THR [3] = '{32, 175, 4096};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ict_pin_n = 1'b1;
	logic rx_bit_strobe = 1'b0;
	logic rx_pos_in = 1'b0;
	logic rx_neg_in = 1'b0;
	logic rx_clk_in = 1'b0;
	logic [`LIUCRT_ADDR_W-1:0] reg_addr;
	logic reg_wr, reg_rd, reg_rdata_oe, rx_clk_out, rx_clk_out_oe;
	logic [7:0] reg_wdata, reg_rdata, q;
	logic rx_positive_data_out, rx_positive_data_out_oe;
	logic rx_negative_violation_out, rx_negative_violation_out_oe;
	logic receive_signal_lost, receive_signal_lost_oe;
	logic [4:0] oe_v;
	liucrt_rate_t synth_rate_select;
	liucrt_gauge_t wire_size_sel;
	int err_total = 0;
	int check_count = 0;
	assign oe_v = {reg_rdata_oe, rx_positive_data_out_oe, rx_negative_violation_out_oe,
		rx_clk_out_oe, receive_signal_lost_oe};
	liucrt_top uut (.*);
	liucrt_host_model host (.*);
	always #2.5 clk = ~clk;
	always @(posedge clk) #1 rx_clk_in = ~rx_clk_in;
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host.access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		host.access(1'b0, a, 8'h00, q);
		chk("rdata", q, e);
	endtask
	task automatic send(input logic b);
		@(posedge clk);
		#1;
		rx_bit_strobe = 1'b1;
		rx_pos_in = b;
		@(posedge clk);
		#1;
		rx_bit_strobe = 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
	initial begin
		settle(3);
		rst = 1'b0;
		chk("oe", oe_v, 5'h1F);
		rd(`LIUCRT_ADDR_CTRL, `LIUCRT_CTRL_RESET);
		rd(`LIUCRT_ADDR_GAUGE, `LIUCRT_GAUGE_RESET);
		wr(`LIUCRT_ADDR_CTRL, 8'hF8);
		chk("rate", synth_rate_select, LIUCRT_RATE_T1J1);
		rd(`LIUCRT_ADDR_CTRL, 8'hF8);
		wr(5'h13, 8'hFF);
		rd(5'h13, 8'h00);
		rd(`LIUCRT_ADDR_CTRL, 8'hF8);
		for (int g = 0; g < 4; g++) begin
			wr(`LIUCRT_ADDR_GAUGE, {g[1:0], 6'h2A});
			chk("gauge", wire_size_sel, g[1:0]);
			rd(`LIUCRT_ADDR_GAUGE, {g[1:0], 6'h2A});
		end
		rx_pos_in = 1'b1;
		rx_neg_in = 1'b1;
		wr(`LIUCRT_ADDR_CTRL, 8'h00);
		chk("rate", synth_rate_select, LIUCRT_RATE_E1);
		chk("pos", rx_positive_data_out, 1'b1);
		chk("neg", rx_negative_violation_out, 1'b1);
		wr(`LIUCRT_ADDR_CTRL, 8'h04);
		settle(1);
		chk("pos", rx_positive_data_out, 1'b0);
		chk("neg", rx_negative_violation_out, 1'b0);
		#1;
		chk("rclk", rx_clk_out, !rx_clk_in);
		rx_neg_in = 1'b0;
		for (int m = 0; m < 3; m++) begin
			wr(`LIUCRT_ADDR_CTRL, LOS_CFG[m]);
			send(1'b1);
			repeat (LOS_THR[m] - 1) send(1'b0);
			settle(2);
			chk("los", receive_signal_lost, 1'b0);
			send(1'b0);
			settle(2);
			chk("los", receive_signal_lost, 1'b1);
		end
		send(1'b1);
		settle(2);
		chk("los", receive_signal_lost, 1'b0);
		wr(`LIUCRT_ADDR_CTRL, 8'h01);
		settle(1);
		chk("oe", oe_v, 5'h00);
		wr(`LIUCRT_ADDR_CTRL, 8'h00);
		settle(1);
		chk("oe", oe_v, 5'h1F);
		ict_pin_n = 1'b0;
		settle(3);
		chk("oe", oe_v, 5'h00);
		ict_pin_n = 1'b1;
		settle(3);
		chk("oe", oe_v, 5'h1F);
		// A reset in mid-run must bring the written gauge register back to its reset value.
		rst = 1'b1;
		settle(3);
		rst = 1'b0;
		rd(`LIUCRT_ADDR_GAUGE, `LIUCRT_GAUGE_RESET);
		chk("gauge", wire_size_sel, 2'h0);
		chk("oe", oe_v, 5'h1F);
		stop_test();
	end
endmodule
`default_nettype wire
